// ===== hw/afc_pkg.sv
// Purpose: Shared constants for the receive FIFO automatic flow control block
// Assumes: 32-bit classic Wishbone register access, 50 MHz core clock
// Notes:   Offsets are byte addresses
package afc_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0]  AUTO_FLOW_CONTROL_CONFIG_OFFSET    = 8'hAC;
   localparam logic [7:0]  AFC_STATUS_OFFSET = 8'hB4;
   localparam logic [31:0] AUTO_FLOW_CONTROL_CONFIG_RESET     = 32'h0000_0000;
   localparam logic [31:0] AUTO_FLOW_CONTROL_CONFIG_WMASK     = 32'h00FF_FFFF;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int HI_LSB      = 16;
   localparam int LO_LSB      = 8;
   localparam int DUR_LSB     = 4;
   localparam int BIT_MCAST   = 3;
   localparam int BIT_BCAST   = 2;
   localparam int BIT_OWN     = 1;
   localparam int BIT_ANY     = 0;
   localparam int UNIT_SHIFT  = 6;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ        = 50;
   localparam int US_CYCLES      = CLK_MHZ;
   localparam int TENTHS_CYCLES  = CLK_MHZ / 10;
   localparam int SLOW_EXTRA_TNT = 22;

   typedef enum logic [1:0] {
      AFC_IDLE,
      AFC_ARMED,
      AFC_PAUSED
   } afc_state_e;
endpackage : afc_pkg

// ===== hw/afc_jam_timer.sv
// Purpose: Times one backpressure burst from a duration code
// Assumes: Start is a one-cycle pulse
// Notes:   Duration in microseconds, plus 2.2 us at 10 Mb/s
`timescale 1ns/1ps
module afc_jam_timer
   import afc_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       start,
   input  wire logic [3:0] code,
   input  wire logic       speed_10,
   output logic            busy
);
   // ****************************************
   // Duration lookup in tenths of a microsecond
   // ****************************************
   function automatic logic [12:0] dur_tenths(input logic [3:0] c, input logic slow);
      logic [12:0] base;
      base = 13'h0000;
      unique case (c)
         4'h0: base = 13'd50;
         4'h1: base = 13'd100;
         4'h2: base = 13'd150;
         4'h3: base = 13'd250;
         default: base = 13'(({9'h000, c} - 13'd3) * 13'd500);
      endcase
      dur_tenths = slow ? 13'(base + 13'(SLOW_EXTRA_TNT)) : base;
   endfunction : dur_tenths

   logic [18:0] count;
   wire  [18:0] load_value = 19'(dur_tenths(code, speed_10) * 19'(TENTHS_CYCLES));

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         count <= 19'h00000;
      end else if (start) begin
         count <= load_value;
      end else if (count != 19'h00000) begin
         count <= count - 19'h00001;
      end
   end

   assign busy = (count != 19'h00000);
endmodule : afc_jam_timer

// ===== hw/afc_flow_ctrl.sv
// Purpose: Automatic flow control driven by receive data FIFO fill level
// Assumes: Frame-type strobes and preamble pulse come from the MAC on core_clk
// Notes:   Pause requests are one-cycle pulses the MAC queues itself

`timescale 1ns/1ps
module afc_flow_ctrl
   import afc_pkg::*;
#(
   parameter int FIFO_CNT_W = 14
)(
   input  wire logic                  core_clk,
   input  wire logic                  sys_rst,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic                  wb_we_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   output logic                       wb_ack_o,
   output logic                       wb_err_o,
   input  wire logic [FIFO_CNT_W-1:0] rx_fifo_bytes,
   input  wire logic                  full_duplex,
   input  wire logic                  speed_10,
   input  wire logic                  tx_enable,
   input  wire logic                  rx_preamble,
   input  wire logic                  rx_addr_valid,
   input  wire logic                  rx_is_multicast,
   input  wire logic                  rx_is_broadcast,
   input  wire logic                  rx_is_own_addr,
   output logic                       pause_request,
   output logic                       pause_zero_time,
   output logic                       jam_active
);
   // ****************************************
   // Register bus
   // ****************************************
   logic [31:0] cfg;
   logic        ack_q;
   afc_state_e  state;
   afc_state_e  next_state;

   // An error answer also closes the request, so err pulses for one cycle only
   wire req       = wb_cyc_i & wb_stb_i & ~ack_q & ~wb_err_o;
   wire hit_cfg   = (wb_adr_i == AUTO_FLOW_CONTROL_CONFIG_OFFSET);
   wire hit_stat  = (wb_adr_i == AFC_STATUS_OFFSET);
   wire hit_any   = hit_cfg | hit_stat;
   wire cfg_write = req & wb_we_i & hit_cfg;

   wire [31:0] sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] wmask    = sel_mask & AUTO_FLOW_CONTROL_CONFIG_WMASK;
   wire [31:0] next_cfg = (cfg & ~wmask) | (wb_dat_i & wmask);
   wire [31:0] status_word;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ack_q    <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         cfg      <= AUTO_FLOW_CONTROL_CONFIG_RESET;
      end else begin
         ack_q    <= req & hit_any;
         wb_err_o <= req & ~hit_any;
         if (req) begin
            wb_dat_o <= hit_cfg ? cfg : (hit_stat ? status_word : 32'h0000_0000);
         end
         if (cfg_write) begin
            cfg <= next_cfg;
         end
      end
   end
   assign wb_ack_o = ack_q;

   // ****************************************
   // Field decode
   // ****************************************
   wire [7:0] high_thr     = cfg[HI_LSB +: 8];
   wire [7:0] low_thr      = cfg[LO_LSB +: 8];
   wire [3:0] dur_code     = cfg[DUR_LSB +: 4];
   wire       trig_any     = cfg[BIT_ANY];
   wire       trig_mcast   = cfg[BIT_MCAST];
   wire       trig_bcast   = cfg[BIT_BCAST];
   wire       trig_own     = cfg[BIT_OWN];
   wire       afc_enabled  = |cfg[3:0];

   // Units of 64 bytes; a partial unit does not count toward a level
   wire [FIFO_CNT_W-1:0] fill_units = rx_fifo_bytes >> UNIT_SHIFT;
   wire level_high = (fill_units >= FIFO_CNT_W'(high_thr));
   wire level_low  = (fill_units <  FIFO_CNT_W'(low_thr));

   assign status_word = {24'h000000, 2'b00, jam_active, level_high, level_low, 1'b0,
                         state == AFC_PAUSED, state == AFC_ARMED};

   // ****************************************
   // Full duplex pause control
   // ****************************************
   // Only the any-frame bit arms full duplex; type bits only keep AFC_PAUSED from dropping when that bit is cleared
   wire fd_active = full_duplex & trig_any & tx_enable;
   wire send_pause = fd_active & (state == AFC_IDLE) & level_high;
   wire send_zero  = tx_enable & (state == AFC_PAUSED) & level_low;

   always_comb begin
      next_state = state;
      unique case (state)
         AFC_IDLE: begin
            if (send_pause) begin
               next_state = AFC_PAUSED;
            end
         end
         AFC_PAUSED: begin
            if (send_zero) begin
               next_state = AFC_IDLE;
            end else if (~full_duplex | ~afc_enabled) begin
               next_state = AFC_IDLE;
            end
         end
         AFC_ARMED: begin
            next_state = AFC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state           <= AFC_IDLE;
         pause_request   <= 1'b0;
         pause_zero_time <= 1'b0;
      end else begin
         state           <= next_state;
         pause_request   <= send_pause | send_zero;
         pause_zero_time <= send_zero;
      end
   end

   // ****************************************
   // Half duplex backpressure
   // ****************************************
   // Any-frame skips address decode and fires on preamble
   wire type_match = (trig_mcast & rx_is_multicast) |
                     (trig_bcast & rx_is_broadcast) |
                     (trig_own   & rx_is_own_addr);
   wire hd_ok      = ~full_duplex & tx_enable & level_high;
   wire jam_any    = hd_ok & trig_any & rx_preamble;
   wire jam_typed  = hd_ok & ~trig_any & rx_addr_valid & type_match;
   wire jam_start  = jam_any | jam_typed;
   logic timer_busy;

   afc_jam_timer u_jam_timer (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .start    (jam_start),
      .code     (dur_code),
      .speed_10 (speed_10),
      .busy     (timer_busy)
   );

   // Drop the jam at once if the transmitter is turned off
   assign jam_active = timer_busy & tx_enable & ~full_duplex;
endmodule : afc_flow_ctrl

// ===== test/afc_monitor.sv
// Purpose: Port checks for afc_flow_ctrl
// Assumes: One clock, sync reset
// Notes:   sent mirrors an open pause episode
`timescale 1ns/1ps
module afc_monitor (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic        tx_enable,
   input wire logic        full_duplex,
   input wire logic        pause_request,
   input wire logic        pause_zero_time,
   input wire logic        jam_active
);
   logic sent;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge core_clk) begin
      if (sys_rst) sent <= 1'b0;
      else if (pause_request) sent <= !pause_zero_time;
   end
   sequence bus_req; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
   sequence bus_done; ##1 (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o); endsequence
   bus_answer_a: assert property (bus_req |-> bus_done)
      else $error("bus answer late");
   upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:24] == 8'h00)
      else $error("reserved bits set");
   tx_off_jam_a: assert property (!tx_enable |-> !jam_active)
      else $error("jam with tx off");
   tx_off_pause_a: assert property (!tx_enable [*2] |-> !pause_request)
      else $error("pause with tx off");
   pause_pulse_a: assert property (pause_request |=> !pause_request)
      else $error("pause longer than one cycle");
   single_pause_a: assert property (pause_request && !pause_zero_time |-> !sent)
      else $error("second pause in episode");
   zero_after_a: assert property (pause_zero_time |-> pause_request && sent)
      else $error("zero pause without episode");
   half_jam_a: assert property (full_duplex |-> !jam_active)
      else $error("jam in full duplex");
   jam_hold_a: assert property ($rose(jam_active) |-> jam_active [*8])
      else $error("jam too short");
endmodule : afc_monitor
bind afc_flow_ctrl afc_monitor u_mon (.*);

// ===== test/afc_link_partner.sv
// Purpose: Frame source standing in for the link
// Assumes: send is entered just after a clock edge
// Notes:   Type lines carry junk outside the strobe
`timescale 1ns/1ps
module afc_link_partner (
   input  wire logic core_clk,
   output logic      rx_preamble,
   output logic      rx_addr_valid,
   output logic      rx_is_multicast,
   output logic      rx_is_broadcast,
   output logic      rx_is_own_addr
);
   initial begin
      rx_preamble = 1'b0;
      rx_addr_valid = 1'b0;
      {rx_is_multicast, rx_is_broadcast, rx_is_own_addr} = 3'h5;
   end
   task send(input logic [2:0] kind);
      rx_preamble <= 1'b1;
      @(posedge core_clk);
      rx_preamble <= 1'b0;
      repeat (3) @(posedge core_clk);
      rx_addr_valid <= 1'b1;
      {rx_is_multicast, rx_is_broadcast, rx_is_own_addr} <= kind;
      @(posedge core_clk);
      rx_addr_valid <= 1'b0;
      // Flipped so a stale type is never mistaken for a match
      {rx_is_multicast, rx_is_broadcast, rx_is_own_addr} <= ~kind;
   endtask : send
endmodule : afc_link_partner

// ===== test/rx_fifo_auto_flow_control_tb_top.sv
// Purpose: Self-checking bench for afc_flow_ctrl
// Assumes: 50 MHz clock, bus answers within 50 cycles
// Notes:   Rows: trigger bits, frame type, jam
`timescale 1ns/1ps
module rx_fifo_auto_flow_control_tb_top import afc_pkg::*; ;
   logic core_clk = 0, sys_rst = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, e;
   logic full_duplex = 0, speed_10 = 0, tx_enable = 1, wb_ack_o, wb_err_o;
   logic [7:0] wb_adr_i = 0;
   logic [31:0] wb_dat_i = 0, wb_dat_o, q;
   logic [3:0] wb_sel_i = 4'hF;
   logic [13:0] rx_fifo_bytes = 0;
   logic rx_preamble, rx_addr_valid, rx_is_multicast, rx_is_broadcast, rx_is_own_addr;
   logic pause_request, pause_zero_time, jam_active;
   int mismatches = 0, samples_checked = 0, n_pause = 0, n_zero = 0, jam_cyc = 0, n;
   logic [7:0] rows [6] = '{8'h89, 8'h84, 8'h45, 8'h23, 8'h28, 8'h11};
   afc_flow_ctrl u_dut (.*);
   afc_link_partner u_lp (.*);
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      n_pause += (pause_request === 1'b1);
      n_zero += (pause_request === 1'b1 && pause_zero_time === 1'b1);
      jam_cyc += (jam_active === 1'b1);
   end
   task chk(input logic [63:0] s, input logic [63:0] x);
      samples_checked++;
      if (s !== x) begin
         mismatches++;
         $display("[ERR] %0t got %h want %h", $time, s, x);
      end
   endtask : chk
   task end_of_test;
      $display("checks %0d errors %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      e = wb_err_o;
      if (n >= 50) begin
         mismatches++;
         end_of_test();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge core_clk);
   endtask : bus
   task settle(input int c);
      repeat (c) @(posedge core_clk);
   endtask : settle
   initial begin
      settle(16);
      sys_rst <= 1'b0;
      bus(0, AUTO_FLOW_CONTROL_CONFIG_OFFSET, 0); chk(q, AUTO_FLOW_CONTROL_CONFIG_RESET);
      bus(1, AUTO_FLOW_CONTROL_CONFIG_OFFSET, 32'hFFFF_FFFF);
      bus(0, AUTO_FLOW_CONTROL_CONFIG_OFFSET, 0); chk(q, AUTO_FLOW_CONTROL_CONFIG_WMASK);
      bus(0, 8'h10, 0); chk(e, 1);
      rx_fifo_bytes <= 14'd128;
      foreach (rows[i]) begin
         bus(1, AUTO_FLOW_CONTROL_CONFIG_OFFSET, {16'h0002, 8'h01, 4'h0, rows[i][7:4]});
         u_lp.send(rows[i][3:1]);
         @(posedge core_clk);
         chk(jam_active, rows[i][0]);
         settle(260);
      end
      speed_10 <= 1'b1;
      bus(1, AUTO_FLOW_CONTROL_CONFIG_OFFSET, 32'h0002_0131);
      jam_cyc = 0;
      u_lp.send(3'b000);
      settle(1400);
      chk(jam_cyc >= 1360 && jam_cyc <= 1361, 1);
      bus(1, AUTO_FLOW_CONTROL_CONFIG_OFFSET, 32'h0002_01F1);
      u_lp.send(3'b000);
      settle(20);
      tx_enable <= 1'b0;
      settle(2);
      chk(jam_active, 0);
      full_duplex <= 1'b1;
      bus(1, AUTO_FLOW_CONTROL_CONFIG_OFFSET, 32'h0004_0201);
      rx_fifo_bytes <= 14'd256;
      settle(20); chk(n_pause, 0);
      rx_fifo_bytes <= 14'd255;
      tx_enable <= 1'b1;
      settle(20); chk(n_pause, 0);
      rx_fifo_bytes <= 14'd256;
      settle(20); chk({n_pause, n_zero}, {32'd1, 32'd0});
      rx_fifo_bytes <= 14'd128;
      settle(20); chk(n_pause, 1);
      rx_fifo_bytes <= 14'd127;
      settle(20); chk({n_pause, n_zero}, {32'd2, 32'd1});
      rx_fifo_bytes <= 14'd200;
      settle(5);
      rx_fifo_bytes <= 14'd0;
      settle(20); chk(n_pause, 2);
      end_of_test();
   end
   initial begin
      settle(20000);
      mismatches++;
      end_of_test();
   end
endmodule : rx_fifo_auto_flow_control_tb_top
